// File: logic/amd_adder.sv
/*
 * Small registered-free 32-bit adder used for every address sum except the pop step of the stack pointer.
 * Assumes operands are already selected; wraps modulo 2^32.
 */
`default_nettype none

module amd_adder (
	input  wire logic [31:0] a,
	input  wire logic [31:0] b,
	output logic      [31:0] sum
);

	// Address arithmetic wraps, as the address space is 32 bits
	assign sum = a + b;

endmodule

`default_nettype wire

// File: logic/amd_decoder.sv
/*
 * Operand addressing-mode decoder: turns a 5-bit mode field with its
 * displacements into an effective address or an immediate value,
 * including pointer fetches and top-of-stack push/pop.
 * Assumes the base registers are stable during a request and that the
 * memory side answers a pointer read with PTR_VALID, one word.
 */
`default_nettype none

module amd_decoder (
	input  wire logic                SYS_CLK,
	input  wire logic                RESETN,
	input  wire logic                REQ_VALID,
	input  wire amd_pkg::amd_req_t   REQ,
	input  wire amd_pkg::amd_bases_t BASES,
	input  wire logic [255:0]        GEN_REGS,
	input  wire logic                PTR_VALID,
	input  wire logic [31:0]         PTR_DATA,
	output logic                     BUSY,
	output logic                     PTR_REQ,
	output logic [31:0]              PTR_ADDR,
	output logic                     RESP_VALID,
	output amd_pkg::amd_resp_t       RESP,
	output logic                     SP_UPDATE,
	output logic                     SP_SEL_USER,
	output logic [31:0]              SP_NEW
);

	amd_pkg::amd_state_t state_reg;
	amd_pkg::amd_state_t state_next;
	logic [31:0]         disp2_reg;
	logic [31:0]         a_op;
	logic [31:0]         b_op;
	logic [31:0]         sum;
	logic [31:0]         ptr_sum;
	logic [31:0]         cur_sp;
	logic                sel_user;
	logic [31:0]         gen_reg;
	logic [31:0]         size_ext;
	logic                is_ptr_mode;
	logic [31:0]         neg_size;
	logic [31:0]         sp_after;
	logic                is_direct_addr;

	// Stack select from the status word
	assign sel_user = BASES.processor_status_word[amd_pkg::PSW_STACK_SEL_BIT];
	assign cur_sp   = sel_user ? BASES.user_stack_pointer
	                           : BASES.interrupt_stack_pointer;
	assign gen_reg  = GEN_REGS[{REQ.mode[2:0], 5'b0_0000} +: 32];
	assign size_ext = {29'h0000_0000, REQ.access_bytes};

	// Push grows the stack downward by the operand size
	assign neg_size = ~size_ext + 32'h0000_0001;

	// Pointer-fetch modes need a memory read before the answer
	assign is_ptr_mode = (REQ.mode == amd_pkg::MODE_MEM_FRAME)
	                  || (REQ.mode == amd_pkg::MODE_MEM_STACK)
	                  || (REQ.mode == amd_pkg::MODE_MEM_STATIC)
	                  || (REQ.mode == amd_pkg::MODE_EXTERNAL);

	// Modes answered straight from the shared adder, no memory read
	assign is_direct_addr = (REQ.mode[4:3] == 2'b01)
	                     || (REQ.mode == amd_pkg::MODE_TOP_STACK)
	                     || (REQ.mode[4:3] == 2'b11 && !REQ.mode[2]);

	// Operand selection for the one shared adder
	// Unlisted modes add disp1 to zero; of these only absolute answers an address
	always_comb begin
		a_op = amd_pkg::RESET_WORD;
		b_op = REQ.disp1;
		if (REQ.mode[4:3] == 2'b01) begin
			a_op = gen_reg;
		end else begin
			case (REQ.mode)
			amd_pkg::MODE_MEM_FRAME:  a_op = BASES.frame_base_register;
			amd_pkg::MODE_MEM_STACK:  a_op = cur_sp;
			amd_pkg::MODE_MEM_STATIC: a_op = BASES.static_base_register;
			amd_pkg::MODE_EXTERNAL: begin
				// Entry index scaled to bytes
				a_op = BASES.link_table_base;
				b_op = {REQ.disp1[29:0], 2'b00};
			end
			amd_pkg::MODE_TOP_STACK: begin
				// Push moves the pointer down before the write
				a_op = cur_sp;
				b_op = REQ.is_write ? neg_size : amd_pkg::RESET_WORD;
			end
			amd_pkg::MODE_SP_FRAME:   a_op = BASES.frame_base_register;
			amd_pkg::MODE_SP_STACK:   a_op = cur_sp;
			amd_pkg::MODE_SP_STATIC:  a_op = BASES.static_base_register;
			amd_pkg::MODE_SP_PROGRAM: a_op = BASES.program_counter;
			default:                  a_op = amd_pkg::RESET_WORD;
			endcase
		end
	end

	// One adder forms every direct address; the second adds disp2 to
	// the fetched pointer in the cycle PTR_VALID brings it, at least two cycles after the address sum
	amd_adder u_addr_add (
		.a   (a_op),
		.b   (b_op),
		.sum (sum)
	);

	amd_adder u_ptr_add (
		.a   (PTR_DATA),
		.b   (disp2_reg),
		.sum (ptr_sum)
	);

	// New pointer after a push or pop; a push leaves it on the word it
	// writes, a pop steps it past the word it read
	assign sp_after = REQ.is_write ? sum : sum + size_ext;

	// Sequencer next state
	// Requests outside idle are dropped, never queued
	always_comb begin
		state_next = state_reg;
		case (state_reg)
		amd_pkg::AMD_IDLE:
			if (REQ_VALID && is_ptr_mode)
				state_next = amd_pkg::AMD_PTR_REQ;
		amd_pkg::AMD_PTR_REQ:  state_next = amd_pkg::AMD_PTR_WAIT;
		amd_pkg::AMD_PTR_WAIT:
			if (PTR_VALID)
				state_next = amd_pkg::AMD_DONE;
		amd_pkg::AMD_DONE:     state_next = amd_pkg::AMD_IDLE;
		default:               state_next = amd_pkg::AMD_IDLE;
		endcase
	end

	// State register; only reset can abandon a pointer fetch
	always_ff @(posedge SYS_CLK or negedge RESETN) begin
		if (!RESETN)
			state_reg <= amd_pkg::AMD_IDLE;
		else
			state_reg <= state_next;
	end

	// Pointer request: address is base plus disp1 (disp1 times 4 for external), held until answered
	// disp2 is kept here since REQ may change while the fetch runs
	always_ff @(posedge SYS_CLK or negedge RESETN) begin
		if (!RESETN) begin
			PTR_REQ   <= 1'b0;
			PTR_ADDR  <= amd_pkg::RESET_WORD;
			disp2_reg <= amd_pkg::RESET_WORD;
		end else if (state_reg == amd_pkg::AMD_IDLE && REQ_VALID
		             && is_ptr_mode) begin
			PTR_REQ   <= 1'b1;
			PTR_ADDR  <= sum;
			disp2_reg <= REQ.disp2;
		end else if (state_reg == amd_pkg::AMD_PTR_WAIT && PTR_VALID) begin
			PTR_REQ   <= 1'b0;
		end
	end

	// Busy while a pointer fetch is outstanding and through the cycle that shows its answer
	// Taken from the next state so it rises in the cycle after a take
	always_ff @(posedge SYS_CLK or negedge RESETN) begin
		if (!RESETN)
			BUSY <= 1'b0;
		else
			BUSY <= (state_next != amd_pkg::AMD_IDLE);
	end

	// Answer: immediate, reserved, direct address or pointer sum
	// Undecoded codes answer reserved with a zero value
	always_ff @(posedge SYS_CLK or negedge RESETN) begin
		if (!RESETN) begin
			RESP_VALID <= 1'b0;
			RESP       <= '{amd_pkg::AMD_KIND_NONE, amd_pkg::RESET_WORD};
		end else begin
			RESP_VALID <= 1'b0;
			if (state_reg == amd_pkg::AMD_PTR_WAIT && PTR_VALID) begin
				RESP_VALID <= 1'b1;
				RESP <= '{amd_pkg::AMD_KIND_ADDRESS, ptr_sum};
			end else if (state_reg == amd_pkg::AMD_IDLE && REQ_VALID
			             && !is_ptr_mode) begin
				RESP_VALID <= 1'b1;
				if (REQ.mode == amd_pkg::MODE_IMMEDIATE)
					RESP <= '{amd_pkg::AMD_KIND_IMMEDIATE,
					          REQ.imm_value};
				else if (REQ.mode == amd_pkg::MODE_ABSOLUTE)
					RESP <= '{amd_pkg::AMD_KIND_ADDRESS, REQ.disp1};
				else if (is_direct_addr)
					RESP <= '{amd_pkg::AMD_KIND_ADDRESS, sum};
				else
					RESP <= '{amd_pkg::AMD_KIND_RESERVED,
					          amd_pkg::RESET_WORD};
			end
		end
	end

	// Top of stack: report new pointer for the selected stack
	// SP_SEL_USER keeps its last value between updates
	always_ff @(posedge SYS_CLK or negedge RESETN) begin
		if (!RESETN) begin
			SP_UPDATE   <= 1'b0;
			SP_SEL_USER <= 1'b0;
			SP_NEW      <= amd_pkg::RESET_WORD;
		end else begin
			SP_UPDATE <= 1'b0;
			if (state_reg == amd_pkg::AMD_IDLE && REQ_VALID
			    && REQ.mode == amd_pkg::MODE_TOP_STACK) begin
				SP_UPDATE   <= 1'b1;
				SP_SEL_USER <= sel_user;
				SP_NEW      <= sp_after;
			end
		end
	end

endmodule

`default_nettype wire

// File: logic/amd_pkg.sv
/*
 * Package for the operand addressing-mode decoder: mode codes, register
 * indices, the request/answer structs and reset values.
 * Assumes a single 40 MHz clock domain; nothing else is shared.
 */
`default_nettype none

package amd_pkg;

	// Mode field codes
	localparam logic [4:0] MODE_REG_REL_LO = 5'h08; // 01000 .. 01111
	localparam logic [4:0] MODE_MEM_FRAME  = 5'h10;
	localparam logic [4:0] MODE_MEM_STACK  = 5'h11;
	localparam logic [4:0] MODE_MEM_STATIC = 5'h12;
	localparam logic [4:0] MODE_RESERVED   = 5'h13;
	localparam logic [4:0] MODE_IMMEDIATE  = 5'h14;
	localparam logic [4:0] MODE_ABSOLUTE   = 5'h15;
	localparam logic [4:0] MODE_EXTERNAL   = 5'h16;
	localparam logic [4:0] MODE_TOP_STACK  = 5'h17;
	localparam logic [4:0] MODE_SP_FRAME   = 5'h18;
	localparam logic [4:0] MODE_SP_STACK   = 5'h19;
	localparam logic [4:0] MODE_SP_STATIC  = 5'h1B - 5'h01;
	localparam logic [4:0] MODE_SP_PROGRAM = 5'h1B;

	// Position of the stack-select bit in the status word
	localparam int PSW_STACK_SEL_BIT = 9;

	// Width of one link table entry in bytes
	localparam logic [31:0] LINK_ENTRY_BYTES = 32'h0000_0004;

	localparam logic [31:0] RESET_WORD = 32'h0000_0000;

	// Result kinds reported with each answer
	typedef enum logic [2:0] {
		AMD_KIND_NONE      = 3'h0,
		AMD_KIND_ADDRESS   = 3'h1,
		AMD_KIND_IMMEDIATE = 3'h2,
		AMD_KIND_RESERVED  = 3'h3
	} amd_kind_t;

	// Sequencer states, Gray coded along the pointer path
	typedef enum logic [1:0] {
		AMD_IDLE     = 2'b00,
		AMD_PTR_REQ  = 2'b01,
		AMD_PTR_WAIT = 2'b11,
		AMD_DONE     = 2'b10
	} amd_state_t;

	// One operand decode request
	typedef struct packed {
		logic [4:0]  mode;
		logic [31:0] disp1;
		logic [31:0] disp2;
		logic [31:0] imm_value;
		logic        is_write;
		logic [2:0]  access_bytes;
	} amd_req_t;

	// Processor base registers seen by the decoder
	typedef struct packed {
		logic [31:0] frame_base_register;
		logic [31:0] static_base_register;
		logic [31:0] interrupt_stack_pointer;
		logic [31:0] user_stack_pointer;
		logic [31:0] program_counter;
		logic [31:0] link_table_base;
		logic [31:0] processor_status_word;
	} amd_bases_t;

	// Decoder answer
	typedef struct packed {
		amd_kind_t   kind;
		logic [31:0] value;
	} amd_resp_t;

endpackage

`default_nettype wire

// File: testbench/addressing_mode_decoder_bench.sv
/* Bench for the addressing-mode decoder: direct, pointer, stack modes.
   Assumes the checker binds itself to the decoder. */
`default_nettype none
module addressing_mode_decoder_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic                SYS_CLK = 0, RESETN = 0, REQ_VALID = 0, PTR_VALID = 0;
	logic                BUSY, PTR_REQ, RESP_VALID, SP_UPDATE, SP_SEL_USER;
	logic [31:0]         PTR_DATA = 32'h0000_0000, PTR_ADDR, SP_NEW;
	logic [255:0]        GEN_REGS;
	amd_pkg::amd_req_t   REQ = '0;
	amd_pkg::amd_bases_t BASES;
	amd_pkg::amd_resp_t  RESP;
	int                  n_mismatch = 0, checked = 0, cyc = 0;
	amd_decoder u_dut (.SYS_CLK(SYS_CLK), .RESETN(RESETN),
		.REQ_VALID(REQ_VALID), .REQ(REQ), .BASES(BASES), .GEN_REGS(GEN_REGS),
		.PTR_VALID(PTR_VALID), .PTR_DATA(PTR_DATA), .BUSY(BUSY),
		.PTR_REQ(PTR_REQ), .PTR_ADDR(PTR_ADDR), .RESP_VALID(RESP_VALID),
		.RESP(RESP), .SP_UPDATE(SP_UPDATE), .SP_SEL_USER(SP_SEL_USER),
		.SP_NEW(SP_NEW));
	// Wide compare so flags and values go in one call
	task automatic chk(input logic [39:0] seen, exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task automatic ans(input amd_pkg::amd_kind_t k, input logic [31:0] v);
		chk({RESP_VALID, RESP}, {1'b1, k, v});
	endtask
	// One request; returns where its direct answer has settled
	task automatic go(input logic [4:0] m, input logic [31:0] d, input logic w);
		@(negedge SYS_CLK);
		REQ.mode = m;
		REQ.disp1 = d;
		REQ.is_write = w;
		REQ_VALID = 1;
		@(negedge SYS_CLK);
		REQ_VALID = 0;
	endtask
	task automatic t_reg_rel;
		logic [31:0] e;
		for (int i = 0; i < 8; i++) begin
			e = 32'h0000_0020 + GEN_REGS[i*32+:32];
			go(5'(5'h08 + i), 32'h0000_0020, 0);
			ans(amd_pkg::AMD_KIND_ADDRESS, e);
		end
	endtask
	task automatic t_space;
		logic [31:0] b [4];
		b = '{BASES.frame_base_register, BASES.interrupt_stack_pointer,
			BASES.static_base_register, BASES.program_counter};
		for (int i = 0; i < 4; i++) begin
			go(5'(amd_pkg::MODE_SP_FRAME + i), 32'h0000_0040, 0);
			ans(amd_pkg::AMD_KIND_ADDRESS, 32'h0000_0040 + b[i]);
		end
	endtask
	task automatic t_imm_resv;
		go(amd_pkg::MODE_IMMEDIATE, 32'h0000_0000, 0);
		ans(amd_pkg::AMD_KIND_IMMEDIATE, REQ.imm_value);
		go(amd_pkg::MODE_RESERVED, 32'h0000_0000, 0);
		ans(amd_pkg::AMD_KIND_RESERVED, 32'h0000_0000);
		// Absolute answers disp1 itself
		go(amd_pkg::MODE_ABSOLUTE, 32'h0000_0123, 0);
		ans(amd_pkg::AMD_KIND_ADDRESS, 32'h0000_0123);
		go(5'h1C, 32'h0000_0123, 0);
		ans(amd_pkg::AMD_KIND_RESERVED, 32'h0000_0000);
	endtask
	// Pointer modes with a slow memory side and refused requests
	task automatic t_ptr;
		logic [31:0] a [4];
		BASES.processor_status_word = 32'h0000_0200;
		a = '{BASES.frame_base_register, BASES.user_stack_pointer,
			BASES.static_base_register, BASES.link_table_base + 32'h0000_0018};
		for (int i = 0; i < 4; i++) begin
			go(i == 3 ? amd_pkg::MODE_EXTERNAL : 5'(5'h10 + i), 32'h0000_0006, 0);
			chk({PTR_REQ, BUSY}, 2'b11);
			chk(PTR_ADDR, a[i] + 32'h0000_0006 * (i < 3));
			// Pointer word offered only once the fetch waits for it
			REQ.mode = amd_pkg::MODE_IMMEDIATE;
			REQ_VALID = i > 0;
			repeat (i + 1) @(negedge SYS_CLK);
			chk({RESP_VALID, PTR_REQ}, 2'b01);
			REQ_VALID = 0;
			PTR_VALID = 1;
			PTR_DATA = 32'h0007_0000 + i;
			@(negedge SYS_CLK);
			PTR_VALID = 0;
			ans(amd_pkg::AMD_KIND_ADDRESS, 32'h0007_0010 + i);
			@(negedge SYS_CLK);
			chk({BUSY, PTR_REQ}, 2'b00);
		end
	endtask
	task automatic t_tos;
		logic [31:0] sp;
		for (int s = 0; s < 2; s++) begin
			BASES.processor_status_word = s ? 32'h0000_0200 : 32'h0000_0000;
			sp = s ? BASES.user_stack_pointer : BASES.interrupt_stack_pointer;
			go(amd_pkg::MODE_TOP_STACK, 32'h0000_0000, 1);
			ans(amd_pkg::AMD_KIND_ADDRESS, sp - 32'h0000_0004);
			chk({SP_UPDATE, SP_NEW}, {1'b1, sp - 32'h0000_0004});
			chk(SP_SEL_USER, s[0]);
			go(amd_pkg::MODE_TOP_STACK, 32'h0000_0000, 0);
			ans(amd_pkg::AMD_KIND_ADDRESS, sp);
			chk({SP_UPDATE, SP_NEW}, {1'b1, sp + 32'h0000_0004});
		end
	endtask
	// Reset in mid-fetch clears every output; then a plain request
	task automatic t_reset;
		go(amd_pkg::MODE_MEM_FRAME, 32'h0000_0006, 0);
		RESETN = 0;
		@(negedge SYS_CLK);
		chk({BUSY, PTR_REQ, RESP_VALID, SP_UPDATE, SP_SEL_USER}, 5'h00);
		chk(PTR_ADDR, 32'h0000_0000);
		chk(RESP, 35'h0);
		chk(SP_NEW, 32'h0000_0000);
		@(negedge SYS_CLK);
		RESETN = 1;
		go(amd_pkg::MODE_IMMEDIATE, 32'h0000_0000, 0);
		ans(amd_pkg::AMD_KIND_IMMEDIATE, REQ.imm_value);
		chk({BUSY, PTR_REQ}, 2'b00);
	endtask
	task automatic tally_and_finish;
		$display("checked %0d n_mismatch %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// Free-running 40 MHz clock and hang guard
	initial begin
		forever #12.5 SYS_CLK = ~SYS_CLK;
	end
	always @(posedge SYS_CLK) begin
		cyc++;
		if (cyc == 1000) begin
			n_mismatch++;
			tally_and_finish();
		end
	end
	initial begin
		BASES = '{32'h0000_1000, 32'h0000_2000, 32'h0000_3000, 32'h0000_4000,
			32'h0000_5000, 32'h0000_6000, 32'h0000_0000};
		for (int i = 0; i < 8; i++) GEN_REGS[i*32+:32] = 32'h0001_0003 * i;
		REQ.disp2 = 32'h0000_0010;
		REQ.imm_value = 32'h0000_abcd;
		REQ.access_bytes = 3'h4;
		repeat (20) @(negedge SYS_CLK);
		RESETN = 1;
		t_reg_rel();
		t_space();
		t_imm_resv();
		t_ptr();
		t_tos();
		t_reset();
		tally_and_finish();
	end
endmodule
`default_nettype wire

// File: testbench/amd_decoder_chk.sv
/* Checker for the addressing-mode decoder: answer timing and values.
   Assumes it sees only the decoder ports, one clock. */
`default_nettype none
module amd_decoder_chk (
	input wire logic                SYS_CLK,
	input wire logic                RESETN,
	input wire logic                REQ_VALID,
	input wire amd_pkg::amd_req_t   REQ,
	input wire amd_pkg::amd_bases_t BASES,
	input wire logic [255:0]        GEN_REGS,
	input wire logic                PTR_VALID,
	input wire logic [31:0]         PTR_DATA,
	input wire logic                BUSY,
	input wire logic                PTR_REQ,
	input wire logic [31:0]         PTR_ADDR,
	input wire logic                RESP_VALID,
	input wire amd_pkg::amd_resp_t  RESP,
	input wire logic                SP_UPDATE,
	input wire logic                SP_SEL_USER,
	input wire logic [31:0]         SP_NEW
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!RESETN);
	// Request taken; selected stack pointer
	wire logic        tk = REQ_VALID && !BUSY;
	wire logic        sel = BASES.processor_status_word[9];
	wire logic [31:0] sp = sel ? BASES.user_stack_pointer
		: BASES.interrupt_stack_pointer;
	sequence s_take(m);
		tk && REQ.mode == m;
	endsequence
	sequence s_addr;
		RESP_VALID && RESP.kind == amd_pkg::AMD_KIND_ADDRESS;
	endsequence
	property p_reg_rel;
		tk && REQ.mode[4:3] == 2'b01 |=> s_addr ##0 RESP.value ==
			$past(REQ.disp1 + GEN_REGS[REQ.mode[2:0] * 32 +: 32]);
	endproperty
	a_reg_rel: assert property (p_reg_rel) else $error("reg sum");
	property p_space;
		s_take(amd_pkg::MODE_SP_FRAME) |=> s_addr ##0 RESP.value ==
			$past(REQ.disp1 + BASES.frame_base_register);
	endproperty
	a_space: assert property (p_space) else $error("space sum");
	property p_resv;
		s_take(amd_pkg::MODE_RESERVED) |=> RESP_VALID && !PTR_REQ &&
			RESP == {amd_pkg::AMD_KIND_RESERVED, 32'h0000_0000};
	endproperty
	a_resv: assert property (p_resv) else $error("reserved");
	property p_imm;
		s_take(amd_pkg::MODE_IMMEDIATE) |=> RESP_VALID && !PTR_REQ &&
			RESP == {amd_pkg::AMD_KIND_IMMEDIATE, $past(REQ.imm_value)};
	endproperty
	a_imm: assert property (p_imm) else $error("immediate");
	property p_ptr;
		tk && REQ.mode inside {5'h10, 5'h11, 5'h12, 5'h16}
			|=> PTR_REQ && BUSY && !RESP_VALID;
	endproperty
	a_ptr: assert property (p_ptr) else $error("no fetch");
	property p_ptr_done;
		$past(PTR_REQ) && PTR_REQ && PTR_VALID |=> s_addr ##0 !PTR_REQ;
	endproperty
	a_ptr_done: assert property (p_ptr_done) else $error("fetch end");
	property p_sel;
		s_take(amd_pkg::MODE_TOP_STACK) |=> SP_UPDATE && SP_SEL_USER == $past(sel);
	endproperty
	a_sel: assert property (p_sel) else $error("stack select");
	property p_tos;
		s_take(amd_pkg::MODE_TOP_STACK) |=> SP_NEW == $past(REQ.is_write ?
			sp - REQ.access_bytes : sp + REQ.access_bytes);
	endproperty
	a_tos: assert property (p_tos) else $error("push pop");
endmodule
bind amd_decoder amd_decoder_chk u_chk (.SYS_CLK(SYS_CLK), .RESETN(RESETN),
	.REQ_VALID(REQ_VALID), .REQ(REQ), .BASES(BASES), .GEN_REGS(GEN_REGS),
	.PTR_VALID(PTR_VALID), .PTR_DATA(PTR_DATA), .BUSY(BUSY),
	.PTR_REQ(PTR_REQ), .PTR_ADDR(PTR_ADDR), .RESP_VALID(RESP_VALID),
	.RESP(RESP), .SP_UPDATE(SP_UPDATE), .SP_SEL_USER(SP_SEL_USER),
	.SP_NEW(SP_NEW));
`default_nettype wire
